// ### design/bbs_defines.svh
// Purpose: constants of the boost/bypass sequencer
// Assumes: 40 MHz pclk
// Notes:   counts derive from the printed durations
`ifndef BBS_DEFINES_SVH
`define BBS_DEFINES_SVH
// ----------------------------------------------------------
// clock and durations
// ----------------------------------------------------------
`define BBS_CLK_KHZ       40000
`define BBS_CHG2_TMO_US   1024
`define BBS_SS_TMO_MS     2
`define BBS_RESTART_MS    1
// microsecond waits round down to whole cycles
`define BBS_CHG2_CYC      ((`BBS_CHG2_TMO_US * `BBS_CLK_KHZ) / 1000)
`define BBS_SS_CYC        (`BBS_SS_TMO_MS * `BBS_CLK_KHZ)
`define BBS_RESTART_CYC   (`BBS_RESTART_MS * `BBS_CLK_KHZ)
// ----------------------------------------------------------
// register map
// ----------------------------------------------------------
`define BBS_REG_CTRL      12'h000
`define BBS_REG_STATUS    12'h004
`define BBS_REG_FAULTS    12'h008
`define BBS_CTRL_AUTO_BIT 0
`define BBS_CTRL_RST      1'h1
`define BBS_CTL_RST       8'hA0  // path open and discharge on
`define BBS_ST_STATE_LSB  0
`define BBS_ST_ENABLE_BIT 3
`define BBS_ST_THERM_BIT  4
`define BBS_ST_POK_BIT    5
`define BBS_FAULTS_W      8
`endif

// ### design/bbs_pkg.sv
// Purpose: shared types of the boost/bypass sequencer
// Assumes: nothing
// Notes:   all eight state codes are legal
package bbs_pkg;
  typedef enum logic [2:0] {
    BBS_OFF    = 3'h0,
    BBS_CHG1   = 3'h1,
    BBS_CHG2   = 3'h2,
    BBS_SOFT   = 3'h3,
    BBS_BOOST  = 3'h4,
    BBS_BYPASS = 3'h5,
    BBS_FAULT  = 3'h6,
    BBS_PASS   = 3'h7
  } bbs_state_t;
endpackage

// ### design/bbs_seq_if.sv
// Purpose: links sequencer, timeout timer and power-good monitor
// Assumes: one clock domain
// Notes:   no clocking block
`timescale 1ns/1ps
`default_nettype none
interface bbs_seq_if #(parameter int TW = 17);
  logic          tmr_restart;
  logic [TW-1:0] tmr_limit;
  logic          tmr_expired;
  logic          ss_done;
  logic          fault_now;
  logic          ilim_trip;
  logic          temp_hot;
  logic          temp_cool;
  logic          thermal_latched;
  logic          pull_low;
  modport seq (output tmr_restart, output tmr_limit, input tmr_expired,
               output ss_done, output fault_now, output ilim_trip,
               output temp_hot, output temp_cool,
               input thermal_latched, input pull_low);
  modport tmr (input tmr_restart, input tmr_limit, output tmr_expired);
  modport mon (input ss_done, input fault_now, input ilim_trip,
               input temp_hot, input temp_cool,
               output thermal_latched, output pull_low);
endinterface
`default_nettype wire

// ### design/bbs_timer.sv
// Purpose: dwell timer for timed sequencer states
// Assumes: restart pulses on every state change
// Notes:   holds at its limit minus one, so untimed states are harmless
`timescale 1ns/1ps
`default_nettype none
module bbs_timer #(
  parameter int TW = 17
) (
  input  wire logic pclk,
  input  wire logic presetn,
  bbs_seq_if.tmr    tif
);
  logic [TW-1:0] cnt_r;
  logic [TW-1:0] cnt_nxt;

  // expiry in the last cycle of the allowed dwell
  assign tif.tmr_expired = (cnt_r == tif.tmr_limit - TW'(1));

  // count up, hold once expired
  always_comb begin
    cnt_nxt = cnt_r;
    if (tif.tmr_restart) begin
      cnt_nxt = '0;
    end else if (!tif.tmr_expired) begin
      cnt_nxt = cnt_r + TW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// ### design/bbs_pwrgood.sv
// Purpose: thermal latch and power-good pull-down
// Assumes: hot/cool come from 120 C rising and 100 C falling comparators
// Notes:   pull_low high means the open-drain flag is driven low
`timescale 1ns/1ps
`default_nettype none
module bbs_pwrgood (
  input  wire logic pclk,
  input  wire logic presetn,
  bbs_seq_if.mon    mif
);
  logic therm_r;
  logic therm_nxt;
  logic pull_r;
  logic pull_nxt;

  assign mif.thermal_latched = therm_r;
  assign mif.pull_low        = pull_r;

  always_comb begin
    // thermal latch hold
    // hot wins over cool so a trip is never lost
    therm_nxt = therm_r;
    if (mif.temp_hot) begin
      therm_nxt = 1'b1;
    end else if (mif.temp_cool) begin
      therm_nxt = 1'b0;
    end
    pull_nxt = !(mif.ss_done && !mif.fault_now && !mif.ilim_trip && !therm_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      therm_r <= 1'b0;
      pull_r  <= 1'b1;
    end else begin
      therm_r <= therm_nxt;
      pull_r  <= pull_nxt;
    end
  end
endmodule
`default_nettype wire

// ### design/bbs_sequencer.sv
// Purpose: startup, mode and fault sequencer of a boost regulator with bypass
// Assumes: comparator inputs synchronous to pclk; APB slave for status/control
// Notes:   outputs select analog functions, they do not regulate
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "bbs_defines.svh"
`default_nettype none

// Summary of operation
// - enable low forces full shutdown
// - force-low pin closes bypass, rest idle
// - select pin picks 3.3V or 3.55V
// - startup needs enable and input above lockout
// - phase one limits 1A, phase two 2A
// - state moves follow voltage comparator conditions
// - phase two over 1024us gives fault
// - switching begins at soft-start entry
// - soft-start over 2ms gives fault
// - fault state opens input-output path
// - fault restarts automatically after 1ms
// - auto mode boost to bypass above target
// - forced pass-through uses 4000mA limit
// - power flag high after soft-start done
// - any fault pulls power flag low
// - current trip or 120C pulls flag low
// - both pins high selects automatic mode; bypass also needs the CTRL auto bit set
// - over-temperature latches regulation off
// - enable low turns on output discharge
module bbs_sequencer #(
  parameter int TW          = 17,
  parameter int CHG2_CYC    = `BBS_CHG2_CYC,
  parameter int SS_CYC      = `BBS_SS_CYC,
  parameter int RESTART_CYC = `BBS_RESTART_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // host pins
  input  wire logic        enable_in,
  input  wire logic        passthrough_force_low,
  input  wire logic        output_level_select,
  // analog comparators
  input  wire logic        vin_above_lockout,
  input  wire logic        vin_above_vout,
  input  wire logic        phase_one_current_low,
  input  wire logic        vout_at_min,
  input  wire logic        vin_above_target,
  input  wire logic        current_limit_trip,
  input  wire logic        temp_above_rise,
  input  wire logic        temp_below_fall,
  // open-drain power flag
  input  wire logic        power_ok_flag_i,
  output var  logic        power_ok_flag_o,
  output var  logic        power_ok_flag_oe,
  // analog controls
  output var  logic        circuit_enable,
  output var  logic        switch_enable,
  output var  logic        bypass_switch,
  output var  logic        charge_limit_phase_one,
  output var  logic        charge_limit_phase_two,
  output var  logic        path_open,
  output var  logic        passthrough_limit_en,
  output var  logic        discharge_on,
  output var  logic        level_high
);
  // ----------------------------------------------------------
  // declarations
  // ----------------------------------------------------------
  bbs_pkg::bbs_state_t state_r;
  bbs_pkg::bbs_state_t state_nxt;
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  logic       level_r;
  logic       level_nxt;
  logic       auto_r;
  logic       auto_nxt;
  logic [`BBS_FAULTS_W-1:0] faults_r;
  logic [`BBS_FAULTS_W-1:0] faults_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic        apb_setup;
  logic        apb_wr;
  logic        addr_ok;

  bbs_seq_if #(.TW(TW)) sif ();

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  bbs_timer #(.TW(TW)) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .tif     (sif.tmr)
  );

  bbs_pwrgood u_pwrgood (
    .pclk    (pclk),
    .presetn (presetn),
    .mif     (sif.mon)
  );

  // monitor feeds; boost or bypass means soft-start completed
  assign sif.ss_done   = (state_r == bbs_pkg::BBS_BOOST) || (state_r == bbs_pkg::BBS_BYPASS);
  assign sif.fault_now = (state_r == bbs_pkg::BBS_FAULT);
  assign sif.ilim_trip = current_limit_trip;
  assign sif.temp_hot  = temp_above_rise;
  assign sif.temp_cool = temp_below_fall;

  // ----------------------------------------------------------
  // state sequencing
  // ----------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (!enable_in) begin
      state_nxt = bbs_pkg::BBS_OFF;
    end else if (!passthrough_force_low) begin
      state_nxt = bbs_pkg::BBS_PASS;
    end else if (!vin_above_lockout || sif.thermal_latched) begin
      // held off below lockout or while the thermal latch is set
      state_nxt = bbs_pkg::BBS_OFF;
    end else begin
      unique case (state_r)
        bbs_pkg::BBS_OFF,
        bbs_pkg::BBS_PASS: begin
          state_nxt = bbs_pkg::BBS_CHG1;
        end
        bbs_pkg::BBS_CHG1: begin
          if (phase_one_current_low) begin
            state_nxt = bbs_pkg::BBS_CHG2;
          end
        end
        bbs_pkg::BBS_CHG2: begin
          if (sif.tmr_expired) begin
            state_nxt = bbs_pkg::BBS_FAULT;
          end else if (!vin_above_vout) begin
            state_nxt = bbs_pkg::BBS_SOFT;
          end
        end
        bbs_pkg::BBS_SOFT: begin
          if (sif.tmr_expired) begin
            state_nxt = bbs_pkg::BBS_FAULT;
          end else if (vout_at_min) begin
            state_nxt = bbs_pkg::BBS_BOOST;
          end
        end
        bbs_pkg::BBS_BOOST: begin
          if (auto_r && vin_above_target) begin
            state_nxt = bbs_pkg::BBS_BYPASS;
          end
        end
        bbs_pkg::BBS_BYPASS: begin
          if (!vin_above_target) begin
            state_nxt = bbs_pkg::BBS_BOOST;
          end
        end
        bbs_pkg::BBS_FAULT: begin
          if (sif.tmr_expired) begin
            state_nxt = bbs_pkg::BBS_CHG1;
          end
        end
      endcase
    end
  end

  // dwell limit per state, cleared on every change
  always_comb begin
    sif.tmr_restart = (state_nxt != state_r);
    unique case (state_r)
      bbs_pkg::BBS_CHG2:  sif.tmr_limit = TW'(CHG2_CYC);
      bbs_pkg::BBS_SOFT:  sif.tmr_limit = TW'(SS_CYC);
      bbs_pkg::BBS_FAULT: sif.tmr_limit = TW'(RESTART_CYC);
      default:            sif.tmr_limit = '1;
    endcase
  end

  // ----------------------------------------------------------
  // output decode
  // ----------------------------------------------------------
  // decoded from the next state and enable_in so pins track state_r exactly
  always_comb begin
    ctl_nxt[0] = enable_in;
    ctl_nxt[1] = (state_nxt == bbs_pkg::BBS_SOFT) || (state_nxt == bbs_pkg::BBS_BOOST);
    ctl_nxt[2] = (state_nxt == bbs_pkg::BBS_PASS) || (state_nxt == bbs_pkg::BBS_BYPASS);
    ctl_nxt[3] = (state_nxt == bbs_pkg::BBS_CHG1);
    ctl_nxt[4] = (state_nxt == bbs_pkg::BBS_CHG2);
    ctl_nxt[5] = (state_nxt == bbs_pkg::BBS_FAULT) || (state_nxt == bbs_pkg::BBS_OFF);
    ctl_nxt[6] = (state_nxt == bbs_pkg::BBS_PASS);
    ctl_nxt[7] = !enable_in;
    level_nxt = output_level_select;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= bbs_pkg::BBS_OFF;
      ctl_r   <= `BBS_CTL_RST;
      level_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctl_r   <= ctl_nxt;
      level_r <= level_nxt;
    end
  end

  assign circuit_enable         = ctl_r[0];
  assign switch_enable          = ctl_r[1];
  assign bypass_switch          = ctl_r[2];
  assign charge_limit_phase_one = ctl_r[3];
  assign charge_limit_phase_two = ctl_r[4];
  assign path_open              = ctl_r[5];
  assign passthrough_limit_en   = ctl_r[6];
  assign discharge_on           = ctl_r[7];
  assign level_high             = level_r;
  // open-drain flag, enable means pull low
  assign power_ok_flag_o        = 1'b0;
  assign power_ok_flag_oe       = sif.pull_low;

  // ----------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------
  // one wait-free access phase: pready rises the cycle after setup
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready_r && pwrite;
  assign addr_ok   = (paddr == `BBS_REG_CTRL) || (paddr == `BBS_REG_STATUS) ||
                     (paddr == `BBS_REG_FAULTS);

  always_comb begin
    auto_nxt    = auto_r;
    faults_nxt  = faults_r;
    prdata_nxt  = prdata_r;
    pready_nxt  = apb_setup;
    pslverr_nxt = apb_setup && !addr_ok;
    if (apb_wr && (paddr == `BBS_REG_CTRL)) begin
      auto_nxt = pwdata[`BBS_CTRL_AUTO_BIT];
    end
    // saturating count of fault entries; a write clears it
    if (apb_wr && (paddr == `BBS_REG_FAULTS)) begin
      faults_nxt = '0;
    end
    if ((state_nxt == bbs_pkg::BBS_FAULT) && (state_r != bbs_pkg::BBS_FAULT) && (faults_nxt != '1)) begin
      faults_nxt = faults_nxt + `BBS_FAULTS_W'(1);
    end
    if (apb_setup) begin
      prdata_nxt = '0;
      if (!pwrite) begin
        unique case (paddr)
          `BBS_REG_CTRL: begin
            prdata_nxt[`BBS_CTRL_AUTO_BIT] = auto_r;
          end
          `BBS_REG_STATUS: begin
            prdata_nxt[`BBS_ST_STATE_LSB +: 3] = state_r;
            prdata_nxt[`BBS_ST_ENABLE_BIT]     = enable_in;
            prdata_nxt[`BBS_ST_THERM_BIT]      = sif.thermal_latched;
            prdata_nxt[`BBS_ST_POK_BIT]        = power_ok_flag_i;
          end
          `BBS_REG_FAULTS: begin
            prdata_nxt[`BBS_FAULTS_W-1:0] = faults_r;
          end
          default: begin
            prdata_nxt = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_r    <= `BBS_CTRL_RST;
      faults_r  <= '0;
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      auto_r    <= auto_nxt;
      faults_r  <= faults_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  // dwell counter seen only by the checks
  logic [TW-1:0] dwell_r;
  logic [TW-1:0] dwell_nxt;
  always_comb begin
    dwell_nxt = (state_nxt != state_r) ? '0 : dwell_r + TW'(dwell_r != '1);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dwell_r <= '0;
    end else begin
      dwell_r <= dwell_nxt;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  shutdown_off_a: assert property (
    !enable_in |=> (state_r == bbs_pkg::BBS_OFF) && !circuit_enable && discharge_on && !switch_enable)
    else $error("enable low did not shut down");

  forced_pass_a: assert property (
    enable_in && !passthrough_force_low |=> bypass_switch && passthrough_limit_en && !switch_enable)
    else $error("forced pass-through not applied");

  level_track_a: assert property (
    ##1 level_high == $past(output_level_select))
    else $error("level select not followed");

  lin_entry_a: assert property (
    (state_r != bbs_pkg::BBS_CHG1) ##1 (state_r == bbs_pkg::BBS_CHG1)
      |-> $past(enable_in) && $past(vin_above_lockout))
    else $error("startup without enable or input");
  lin_limits_a: assert property (
    (state_r == bbs_pkg::BBS_CHG2) |-> charge_limit_phase_two && !charge_limit_phase_one && !switch_enable)
    else $error("phase two limit wrong");
  charge_timeout_a: assert property (
    (state_r == bbs_pkg::BBS_CHG2) ##1 (state_r == bbs_pkg::BBS_FAULT) |-> $past(dwell_r) == TW'(CHG2_CYC - 1))
    else $error("phase two timeout length wrong");
  ss_timeout_a: assert property (
    (state_r == bbs_pkg::BBS_SOFT) |-> dwell_r < TW'(SS_CYC))
    else $error("soft-start overstayed");
  fault_open_a: assert property (
    (state_r == bbs_pkg::BBS_FAULT) |-> path_open && !bypass_switch && !switch_enable)
    else $error("fault path not open");
  restart_time_a: assert property (
    (state_r == bbs_pkg::BBS_FAULT) ##1 (state_r == bbs_pkg::BBS_CHG1) |-> $past(dwell_r) == TW'(RESTART_CYC - 1))
    else $error("restart delay wrong");

  flag_low_a: assert property (
    (state_r == bbs_pkg::BBS_FAULT) |=> power_ok_flag_oe)
    else $error("fault left power flag high");
endmodule
`default_nettype wire

// ### testbench/bbs_host_model.sv
// Purpose: host controller model driving the sequencer pins
// Assumes: pins change just after pclk rising edges
// Notes:   auto request is held back until the enable delay has run
`timescale 1ns/1ps
`default_nettype none
module bbs_host_model #(
  parameter int DLY_CYC = 2400
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic want_on,
  input  wire logic want_auto,
  input  wire logic level_req,
  output var  logic enable_in,
  output var  logic passthrough_force_low,
  output var  logic output_level_select
);
  // ------------------------------------------------
  // pin sequencing
  // ------------------------------------------------
  int unsigned cnt_r;
  // enable delay count
  // the delay starts at the enable rise, so auto mode never races startup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r                 <= 0;
      enable_in             <= 1'b0;
      passthrough_force_low <= 1'b0;
      output_level_select   <= 1'b0;
    end else begin
      enable_in             <= want_on;
      cnt_r                 <= (want_on && enable_in) ? ((cnt_r < DLY_CYC) ? cnt_r + 1 : cnt_r) : 0;
      passthrough_force_low <= want_on && want_auto && (cnt_r >= DLY_CYC);
      output_level_select   <= level_req;
    end
  end
endmodule
`default_nettype wire

// ### testbench/boost_bypass_mode_sequencer_tb.sv
// Purpose: self-checking bench of the boost/bypass sequencer
// Assumes: 40 MHz pclk, shortened timeout parameters
// Notes:   the open-drain power flag has its pull-up here
`timescale 1ns/1ps
`default_nettype none
module boost_bypass_mode_sequencer_tb;
  // ------------------------------------------------
  // signals and instances
  // ------------------------------------------------
  localparam int L2 = 20;
  localparam int SS = 40;
  localparam int RS = 10;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        want_on, want_auto, level_req, en, fl, lsel;
  logic        lock, vinvo, p1ok, vmin, vtgt, ilim, hot, cool;
  logic        pok_o, pok_oe, cen, swe, byp, cl1, cl2, popen, ptl, dis, lvl;
  wire logic   pok_pin = pok_oe ? pok_o : 1'b1;  // pull-up when released
  int          fail_count, num_checks, n;

  bbs_host_model #(.DLY_CYC(2400)) host_u (.pclk(pclk), .presetn(presetn), .want_on(want_on),
    .want_auto(want_auto), .level_req(level_req), .enable_in(en), .passthrough_force_low(fl),
    .output_level_select(lsel));
  bbs_sequencer #(.CHG2_CYC(L2), .SS_CYC(SS), .RESTART_CYC(RS)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enable_in(en), .passthrough_force_low(fl),
    .output_level_select(lsel), .vin_above_lockout(lock), .vin_above_vout(vinvo), .phase_one_current_low(p1ok),
    .vout_at_min(vmin), .vin_above_target(vtgt), .current_limit_trip(ilim), .temp_above_rise(hot),
    .temp_below_fall(cool), .power_ok_flag_i(pok_pin), .power_ok_flag_o(pok_o), .power_ok_flag_oe(pok_oe),
    .circuit_enable(cen), .switch_enable(swe), .bypass_switch(byp), .charge_limit_phase_one(cl1),
    .charge_limit_phase_two(cl2), .path_open(popen), .passthrough_limit_en(ptl), .discharge_on(dis),
    .level_high(lvl));

  // clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task automatic report_and_stop();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // expected status word, enable pin high
  function automatic logic [31:0] stat(input logic p, input logic t, input bbs_pkg::bbs_state_t s);
    return {26'h0, p, t, 1'b1, s};
  endfunction
  task automatic step(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return popen;
      1: return fl;
      2: return swe;
      default: return pok_oe;
    endcase
  endfunction
  // bounded wait, n counts the edges it took
  task automatic wait_sig(input int s, input logic v);
    n = 0;
    while (pick(s) !== v && n < 3000) begin
      step(1);
      n++;
    end
  endtask
  // one apb transfer; answer taken at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // values read here are those the edge sampled; the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk_bit(pready, 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // watchdog, far beyond the few thousand cycles needed
  initial begin
    #(20000 * 25);
    fail_count++;
    report_and_stop();
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    fail_count = 0;
    num_checks = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, want_on, want_auto, level_req, lock, p1ok, vmin, vtgt, ilim, hot, cool} = '0;
    vinvo = 1'b1;
    void'($urandom(32'h67BE0AF4));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    step(1);
    chk_bit(dis, 1'b1);
    chk_bit(pok_oe, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk_word(rd, 32'h1);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF);
    chk_bit(er, 1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    chk_word(rd, 32'h0);
    // forced pass-through while the host waits out its delay
    @(posedge pclk);
    want_on   <= 1'b1;
    want_auto <= 1'b1;
    step(3);
    chk_bit(cen, 1'b1);
    chk_bit(byp, 1'b1);
    chk_bit(swe, 1'b0);
    chk_bit(ptl, 1'b1);
    wait_sig(1, 1'b1);
    step(2);
    chk_bit(cl1, 1'b0);
    chk_bit(popen, 1'b1);
    @(posedge pclk);
    lock <= 1'b1;
    step(2);
    chk_bit(cl1, 1'b1);
    chk_bit(popen, 1'b0);
    // phase two stuck, then restart
    @(posedge pclk);
    p1ok <= 1'b1;
    step(2);
    chk_bit(cl2, 1'b1);
    wait_sig(0, 1'b1);
    chk_bit(n >= L2 - 4 && n <= L2 + 1, 1'b1);
    chk_bit(pok_oe, 1'b1);
    chk_bit(swe, 1'b0);
    @(posedge pclk);
    p1ok <= 1'b0;
    wait_sig(0, 1'b0);
    chk_bit(n >= RS - 3 && n <= RS + 1, 1'b1);
    chk_bit(cl1, 1'b1);
    chk_bit(cl2, 1'b0);
    // soft-start stuck, then restart
    @(posedge pclk);
    p1ok  <= 1'b1;
    vinvo <= 1'b0;
    wait_sig(2, 1'b1);
    chk_bit(cl2, 1'b0);
    wait_sig(0, 1'b1);
    chk_bit(n >= SS - 2 && n <= SS + 1, 1'b1);
    @(posedge pclk);
    p1ok  <= 1'b0;
    vinvo <= 1'b1;
    wait_sig(0, 1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chk_word(rd, 32'h2);
    // full start into boost, then bypass under auto control
    @(posedge pclk);
    p1ok  <= 1'b1;
    vinvo <= 1'b0;
    vmin  <= 1'b1;
    wait_sig(3, 1'b0);
    chk_bit(n < 10, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    chk_word(rd, stat(1'b1, 1'b0, bbs_pkg::BBS_BOOST));
    @(posedge pclk);
    vtgt <= 1'b1;
    step(3);
    chk_bit(byp, 1'b1);
    apb(1'b1, 12'h000, 32'h0);
    @(posedge pclk);
    vtgt <= 1'b0;
    step(3);
    chk_bit(byp, 1'b0);
    @(posedge pclk);
    vtgt <= 1'b1;
    step(3);
    chk_bit(byp, 1'b0);
    apb(1'b1, 12'h000, 32'h1);
    step(3);
    chk_bit(byp, 1'b1);
    // over-temperature latch
    @(posedge pclk);
    hot <= 1'b1;
    step(3);
    chk_bit(popen, 1'b1);
    chk_bit(pok_oe, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    chk_word(rd, stat(1'b0, 1'b1, bbs_pkg::BBS_OFF));
    @(posedge pclk);
    hot <= 1'b0;
    step(3);
    chk_bit(popen, 1'b1);
    @(posedge pclk);
    cool <= 1'b1;
    wait_sig(3, 1'b0);
    chk_bit(n < 20, 1'b1);
    // random level select and current trips in bypass
    repeat (16) begin
      @(posedge pclk);
      level_req <= 1'($urandom);
      ilim      <= ($urandom % 4) == 0;
      step(3);
      chk_bit(lvl, level_req);
      chk_bit(pok_oe, ilim);
    end
    // clear fault count, then shut down
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk_word(rd, 32'h0);
    @(posedge pclk);
    want_on <= 1'b0;
    step(3);
    chk_bit(cen, 1'b0);
    chk_bit(dis, 1'b1);
    chk_bit(pok_oe, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
